/* logic/vds_pkg.sv */
// constants shared by the display scan driver
package vds_pkg;
   // storage layout
   localparam int DIGITS  = 8;
   localparam int BCD_W   = 4;
   localparam int SLOT_W  = 5;
   localparam int SLOT_PT = 4;
   localparam int SEG_W   = 7;
   localparam int IDX_W   = 3;
   localparam int CNT_W   = 4;
   localparam int SR_W    = DIGITS * SLOT_W;

   // transport edge counter
   localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;
   localparam logic [CNT_W-1:0] CNT_LOAD  = 4'h8;
   localparam logic [CNT_W-1:0] CNT_NINTH = 4'h9;

   // reset values
   localparam logic [SR_W-1:0]   SR_RST    = 40'h00_0000_0000;
   localparam logic [SEG_W-1:0]  SEG_OFF   = 7'h00;
   localparam logic [DIGITS-1:0] DIGIT_OFF = 8'h00;
   localparam logic [DIGITS-1:0] DIGIT_ONE = 8'h01;
   localparam logic [IDX_W-1:0]  IDX_RST   = 3'h0;
   localparam logic [IDX_W-1:0]  IDX_STEP  = 3'h1;

   // scan oscillator: period in ns is factor times capacitance in pF
   localparam int CLK_PERIOD_NS  = 100;
   localparam int OSC_FACTOR     = 20;
   localparam int CEXT_PF        = 1000;
   localparam int SCAN_PERIOD_NS = OSC_FACTOR * CEXT_PF;
   localparam int SCAN_CYCLES_RAW = SCAN_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SCAN_CYCLES    = (SCAN_CYCLES_RAW < 1) ? 1 : SCAN_CYCLES_RAW;
   localparam int SCAN_CNT_W     = 8;
   localparam logic [SCAN_CNT_W-1:0] SCAN_LAST = SCAN_CNT_W'(SCAN_CYCLES - 1);
   localparam logic [SCAN_CNT_W-1:0] SCAN_ZERO = 8'h00;
   localparam logic [SCAN_CNT_W-1:0] SCAN_STEP = 8'h01;

   // segment codes, bit 0 = a ... bit 6 = g
   localparam logic [15:0][SEG_W-1:0] SEG_TABLE = {
      7'h00,  // F blank
      7'h07,  // E "7"
      7'h38,  // D "L"
      7'h73,  // C "P"
      7'h79,  // B "E"
      7'h40,  // A "-"
      7'h6F, 7'h7F, 7'h07, 7'h7D, 7'h6D,
      7'h66, 7'h4F, 7'h5B, 7'h06, 7'h3F
   };
endpackage

/* logic/vds_scan_if.sv */
// scan step and digit index passed from the oscillator to the driver
`timescale 1ns/1ns
`default_nettype none
interface vds_scan_if;
   logic                     tick;
   logic [vds_pkg::IDX_W-1:0] idx;
   modport src (output tick, output idx);
   modport dst (input tick, input idx);
endinterface
`default_nettype wire

/* logic/vds_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module vds_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // levels
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule
`default_nettype wire

/* logic/vds_scan.sv */
// scan oscillator and digit index counter
`timescale 1ns/1ns
`default_nettype none
module vds_scan
   import vds_pkg::*;
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic resetn,
   // scan position
   vds_scan_if.src   scan
);
   logic [SCAN_CNT_W-1:0] osc_r;
   logic [IDX_W-1:0]      idx_r;
   wire                   wrap = (osc_r == SCAN_LAST);

   assign scan.tick = wrap;
   assign scan.idx  = idx_r;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         osc_r <= SCAN_ZERO;
         idx_r <= IDX_RST;
      end else begin
         osc_r <= wrap ? SCAN_ZERO : osc_r + SCAN_STEP;
         if (wrap) begin
            idx_r <= idx_r + IDX_STEP;
         end
      end
   end
endmodule
`default_nettype wire

/* logic/vds_driver.sv */
// eight digit display decoder and scan driver, top level
`timescale 1ns/1ns
`default_nettype none
module vds_driver
   import vds_pkg::*;
(
   // system clock and reset
   input  wire logic                  mclk,
   input  wire logic                  resetn,
   // transport link from the host
   input  wire logic                  xfer_clk,
   input  wire logic                  bcd_in_1,
   input  wire logic                  bcd_in_2,
   input  wire logic                  bcd_in_4,
   input  wire logic                  bcd_in_8,
   input  wire logic                  point_in,
   input  wire logic                  counter_rst,
   input  wire logic                  load_in,
   input  wire logic                  output_enable,
   // display drive
   output var  logic [vds_pkg::SEG_W-1:0]  seg_out,
   output var  logic                       point_out,
   output var  logic [vds_pkg::DIGITS-1:0] digit_out
);
   // ---------------- link domain (xfer_clk) ----------------
   logic [SR_W-1:0]   sr_r;
   logic [CNT_W-1:0]  cnt_r;
   logic              evt_r;
   wire  [SLOT_W-1:0] din       = {point_in, bcd_in_8, bcd_in_4, bcd_in_2, bcd_in_1};
   wire               cnt_clr_n = resetn & ~counter_rst;
   wire               cnt_sat   = (cnt_r == CNT_NINTH);

   // newest digit enters slot 0, older digits move up
   always_ff @(posedge xfer_clk or negedge resetn) begin
      if (!resetn) begin
         sr_r  <= SR_RST;
         evt_r <= 1'b0;
      end else begin
         sr_r  <= {sr_r[SR_W-SLOT_W-1:0], din};
         evt_r <= ~evt_r;
      end
   end

   // edge counter, saturating at nine so later edges still count as ninth
   always_ff @(posedge xfer_clk or negedge cnt_clr_n) begin
      if (!cnt_clr_n) begin
         cnt_r <= CNT_ZERO;
      end else if (!cnt_sat) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end

   // ---------------- crossing into mclk ----------------
   // sr_r and cnt_r are read only once evt_r's toggle has passed the
   // synchroniser; they stay still after it until the next transport edge or, for cnt_r, a counter reset
   logic evt_s;
   logic rst_s;
   logic load_s;
   logic en_s;

   vds_sync #(.W(1)) u_sync_evt (
      .clk   (mclk),
      .rst_n (resetn),
      .d     (evt_r),
      .q     (evt_s)
   );

   vds_sync #(.W(3)) u_sync_pins (
      .clk   (mclk),
      .rst_n (resetn),
      .d     ({counter_rst, load_in, output_enable}),
      .q     ({rst_s, load_s, en_s})
   );

   // ---------------- mclk domain ----------------
   logic                     evt_seen_r;
   logic                     load_d_r;
   logic [SR_W-1:0]          sr_m_r;
   logic [CNT_W-1:0]         cnt_m_r;
   logic [SR_W-1:0]          latch_r;
   logic [SR_W-1:0]          latch_nxt;
   logic [SEG_W-1:0]         seg_nxt;
   logic                     point_nxt;
   logic [DIGITS-1:0]        digit_nxt;

   // new transport edge seen this cycle
   wire upd       = evt_s ^ evt_seen_r;
   wire load_rise = load_s & ~load_d_r;

   // automatic transfer: load level high, reset low, edge count eight or nine
   wire auto_ld   = upd & load_s & ~rst_s
                    & ((cnt_r == CNT_LOAD) | (cnt_r == CNT_NINTH));

   // strobed transfer: only on exactly eight edges, reset low, no edge pending
   wire strobe_ld = load_rise & ~upd & ~rst_s & (cnt_m_r == CNT_LOAD);

   assign latch_nxt = auto_ld   ? sr_r   :
                      strobe_ld ? sr_m_r : latch_r;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         evt_seen_r <= 1'b0;
         load_d_r   <= 1'b0;
         sr_m_r     <= SR_RST;
         cnt_m_r    <= CNT_ZERO;
      end else begin
         evt_seen_r <= evt_s;
         load_d_r   <= load_s;
         if (upd) begin
            sr_m_r  <= sr_r;
         end
         if (rst_s) begin
            cnt_m_r <= CNT_ZERO;
         end else if (upd) begin
            cnt_m_r <= cnt_r;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         latch_r <= SR_RST;
      end else begin
         latch_r <= latch_nxt;
      end
   end

   // ---------------- scan and decode ----------------
   vds_scan_if scan_bus ();

   vds_scan u_scan (
      .mclk   (mclk),
      .resetn (resetn),
      .scan   (scan_bus)
   );

   wire [SLOT_W-1:0] slot_cur = latch_r[scan_bus.idx*SLOT_W +: SLOT_W];
   wire [BCD_W-1:0]  bcd_cur  = slot_cur[BCD_W-1:0];

   assign seg_nxt   = en_s ? SEG_TABLE[bcd_cur] : SEG_OFF;
   assign point_nxt = en_s & slot_cur[SLOT_PT];
   assign digit_nxt = en_s ? (DIGIT_ONE << scan_bus.idx) : DIGIT_OFF;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         seg_out   <= SEG_OFF;
         point_out <= 1'b0;
         digit_out <= DIGIT_OFF;
      end else begin
         seg_out   <= seg_nxt;
         point_out <= point_nxt;
         digit_out <= digit_nxt;
      end
   end

   // ---------------- checks ----------------
   logic [IDX_W-1:0] idx_q_r;
   logic [SR_W-1:0]  latch_q_r;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         idx_q_r   <= IDX_RST;
         latch_q_r <= SR_RST;
      end else begin
         idx_q_r   <= scan_bus.idx;
         latch_q_r <= latch_r;
      end
   end

   blank_out_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      !en_s |=> (seg_out == SEG_OFF) && (digit_out == DIGIT_OFF) && !point_out
   ) else $error("outputs not blanked while disabled");

   digit_onehot_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      $past(en_s) |-> (digit_out == (DIGIT_ONE << idx_q_r))
   ) else $error("digit output does not match scan index");

   scan_step_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      scan_bus.tick |=> (scan_bus.idx == $past(scan_bus.idx) + IDX_STEP)
                        ##1 !scan_bus.tick [*8]
   ) else $error("scan index did not advance once per period");

   seg_decode_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      en_s |=> (seg_out == SEG_TABLE[$past(bcd_cur)])
   ) else $error("segment pattern does not match code");

   point_follow_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      en_s && slot_cur[SLOT_PT] |=> point_out
   ) else $error("point segment missing");

   early_load_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      load_rise && !upd && (cnt_m_r < CNT_LOAD) |=> (latch_r == latch_q_r)
   ) else $error("strobe accepted before eighth edge");

   ninth_ignore_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      load_rise && !upd && (cnt_m_r == CNT_NINTH) |=> $stable(latch_r)
   ) else $error("strobe accepted after ninth edge");

   reset_block_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      rst_s |=> $stable(latch_r)
   ) else $error("latch changed while counter reset high");

   strobe_load_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      load_rise && !upd && !rst_s && (cnt_m_r == CNT_LOAD)
      |=> (latch_r == $past(sr_m_r))
   ) else $error("valid strobe did not copy shift register");

   auto_load_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      upd && load_s && !rst_s && (cnt_r == CNT_LOAD) |=> (latch_r == $past(sr_r))
   ) else $error("automatic transfer missing at eighth edge");

   count_clear_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      rst_s |=> (cnt_m_r == CNT_ZERO)
   ) else $error("edge count not cleared by counter reset");

   // latch moves only on an accepted transfer; sr_m_r follows each edge, cnt_m_r each edge while rst_s is low, cnt_m_r stays at or below nine
   ninth_auto_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      upd && load_s && !rst_s && (cnt_r == CNT_NINTH) |=> (latch_r == $past(sr_r))
   ) else $error("automatic transfer missing at ninth edge");

   auto_early_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      upd && (cnt_r < CNT_LOAD) |=> (latch_r == latch_q_r)
   ) else $error("automatic transfer before eighth edge");

   load_low_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      upd && !load_s |=> (latch_r == latch_q_r)
   ) else $error("transfer on edge with load low");

   idle_hold_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      !upd && !load_rise |=> (latch_r == latch_q_r)
   ) else $error("latch changed without edge or strobe");

   reset_strobe_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      rst_s && load_rise |=> (latch_r == latch_q_r)
   ) else $error("strobe accepted under counter reset");

   copy_track_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      upd |=> (sr_m_r == $past(sr_r))
   ) else $error("shift register copy not refreshed");

   count_copy_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      upd && !rst_s |=> (cnt_m_r == $past(cnt_r))
   ) else $error("edge count copy not refreshed");

   count_limit_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      cnt_m_r <= CNT_NINTH
   ) else $error("edge count beyond ninth");

   // outputs, scan steps and transport shifting
   point_dark_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      en_s && !slot_cur[SLOT_PT] |=> !point_out
   ) else $error("point segment lit without point bit");

   digit_single_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      $onehot0(digit_out)
   ) else $error("more than one digit driven");

   scan_tick_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      scan_bus.tick |=> !scan_bus.tick
   ) else $error("scan step lasted more than one cycle");

   shift_in_a: assert property (
      @(posedge xfer_clk) disable iff (!resetn)
      1'b1 |=> (sr_r[SLOT_W-1:0] == $past(din))
                && (sr_r[SR_W-1:SLOT_W] == $past(sr_r[SR_W-SLOT_W-1:0]))
   ) else $error("digit not shifted in on transport edge");
endmodule
`default_nettype wire

/* bench/vds_host.sv */
// host model driving the transport link of the display driver
`timescale 1ns/1ns
`default_nettype none
module vds_host (
   // transport link
   output var logic       xfer_clk,
   output var logic [4:0] din,
   output var logic       counter_rst,
   output var logic       load_in
);
   logic lclk;
   initial begin
      lclk = 1'b0;
      xfer_clk = 1'b0;
      din = 5'h00;
      counter_rst = 1'b0;
      load_in = 1'b0;
   end
   always #3 lclk = ~lclk;
   task automatic gap(input int n);
      repeat (n) @(posedge lclk);
   endtask
   // one digit: setup, rising edge, then stale data
   task automatic shift(input logic [4:0] d);
      gap(1);
      din <= d;
      gap(50);
      xfer_clk <= 1'b1;
      gap(50);
      xfer_clk <= 1'b0;
      gap(25);
      din <= ~d;
      gap(25);
   endtask
   task automatic set_rst(input logic v);
      gap(1);
      counter_rst <= v;
      gap(100);
   endtask
   task automatic set_load(input logic v);
      gap(1);
      load_in <= v;
      gap(100);
   endtask
   task automatic clr;
      set_rst(1'b1);
      set_rst(1'b0);
   endtask
   // strobe leaves counter reset as it is
   task automatic strobe;
      gap(100);
      set_load(1'b1);
      set_load(1'b0);
   endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench of the display scan driver
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import vds_pkg::*;
   logic              mclk;
   logic              resetn;
   logic              output_enable;
   logic              xfer_clk;
   logic              counter_rst;
   logic              load_in;
   logic              point_out;
   logic [4:0]        din;
   logic [SEG_W-1:0]  seg_out;
   logic [DIGITS-1:0] digit_out;
   logic [4:0]        sr [8];
   logic [4:0]        lat [8];
   logic [SEG_W-1:0]  tbl [16];
   int                n_errors = 0;
   int                total_checks = 0;

   initial mclk = 1'b0;
   always #50 mclk = ~mclk;

   vds_host i_host (.xfer_clk(xfer_clk), .din(din), .counter_rst(counter_rst),
      .load_in(load_in));
   vds_driver i_dut (.mclk(mclk), .resetn(resetn), .xfer_clk(xfer_clk),
      .bcd_in_1(din[0]), .bcd_in_2(din[1]), .bcd_in_4(din[2]), .bcd_in_8(din[3]),
      .point_in(din[4]), .counter_rst(counter_rst), .load_in(load_in),
      .output_enable(output_enable), .seg_out(seg_out), .point_out(point_out),
      .digit_out(digit_out));

   task automatic end_of_test;
      if (n_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // shift n digits into the device and the bench copy
   task automatic frame(input logic [3:0] base, input int n, input logic [8:0] pts);
      logic [4:0] d;
      for (int k = 0; k < n; k++) begin
         d = {pts[k], base + 4'(k)};
         i_host.shift(d);
         for (int j = 7; j > 0; j--) sr[j] = sr[j-1];
         sr[0] = d;
      end
   endtask
   // one full scan compared with the expected latch
   task automatic show;
      int w;
      repeat (4) @(negedge mclk);
      for (int i = 0; i < 8; i++) begin
         w = 0;
         do begin
            @(negedge mclk);
            w++;
         end while (digit_out !== (DIGIT_ONE << i) && w < 2000);
         chk(digit_out, DIGIT_ONE << i);
         chk(seg_out, tbl[lat[i][3:0]]);
         chk(point_out, lat[i][4]);
      end
   endtask
   task automatic t_strobe;
      i_host.clr;
      frame(4'h0, 7, 9'h05A);
      i_host.strobe;
      show;
      frame(4'h7, 1, 9'h000);
      show;
      i_host.strobe;
      lat = sr;
      show;
   endtask
   task automatic t_auto;
      i_host.clr;
      i_host.set_load(1'b1);
      frame(4'h8, 8, 9'h0A5);
      lat = sr;
      show;
      frame(4'hC, 1, 9'h001);
      lat = sr;
      show;
      i_host.set_load(1'b0);
   endtask
   task automatic t_ninth;
      i_host.clr;
      frame(4'h3, 9, 9'h1FF);
      i_host.strobe;
      show;
   endtask
   // strobe under counter reset, then too few edges after it
   task automatic t_rst;
      i_host.clr;
      frame(4'h1, 8, 9'h000);
      i_host.set_rst(1'b1);
      i_host.strobe;
      i_host.set_rst(1'b0);
      show;
      frame(4'h2, 7, 9'h011);
      i_host.strobe;
      show;
      frame(4'h9, 1, 9'h001);
      i_host.strobe;
      lat = sr;
      show;
   endtask
   task automatic t_blank;
      @(posedge mclk);
      output_enable <= 1'b0;
      repeat (8) begin
         repeat (200) @(negedge mclk);
         chk({seg_out, point_out, digit_out}, 32'h0000);
      end
      @(posedge mclk);
      output_enable <= 1'b1;
      show;
   endtask
   task automatic t_scan;
      logic [7:0]  prev;
      logic [31:0] n;
      for (int k = 0; k < 9; k++) begin
         prev = digit_out;
         n = 0;
         do begin
            @(negedge mclk);
            n++;
         end while (digit_out === prev && n < 1000);
         if (k > 0) begin
            chk(n, 32'(SCAN_CYCLES));
            chk(digit_out, {prev[6:0], prev[7]});
         end
      end
   endtask
   task automatic t_reset;
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(negedge mclk);
      chk({seg_out, point_out, digit_out}, 32'h0000);
      @(posedge mclk);
      output_enable <= 1'b1;
      show;
   endtask

   initial begin
      resetn = 1'b0;
      output_enable = 1'b0;
      tbl = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
              7'h7F, 7'h6F, 7'h40, 7'h79, 7'h73, 7'h38, 7'h07, 7'h00};
      for (int j = 0; j < 8; j++) begin
         sr[j] = 5'h00;
         lat[j] = 5'h00;
      end
      t_reset;
      t_strobe;
      t_auto;
      t_ninth;
      t_rst;
      t_blank;
      t_scan;
      end_of_test;
   end
   // cut a hang short
   initial begin
      #6_000_000;
      n_errors++;
      end_of_test;
   end
endmodule
`default_nettype wire
